// ---- core/bccd_top.sv ----
`timescale 1ns/10ps
`include "bccd_consts.svh"
module bccd_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // command issue
  input  wire logic        cmd_valid_i,
  input  wire logic [63:0] cmd_mdptr_i,
  input  wire logic [63:0] cmd_first_page_pointer_i,
  input  wire logic [63:0] cmd_second_page_pointer_i,
  input  wire logic [31:0] cmd_dw10_i,
  input  wire logic [31:0] cmd_dw11_i,
  input  wire logic [31:0] cmd_dw12_i,
  input  wire logic [31:0] cmd_dw13_i,
  input  wire logic [31:0] cmd_dw14_i,
  input  wire logic [31:0] cmd_dw15_i,
  input  wire logic        cmd_has_md_i,
  output logic             cmd_ready_o,
  // per block compare results from the datapath
  input  wire logic        blk_valid_i,
  input  wire logic        blk_data_eq_i,
  input  wire logic        blk_md_eq_i,
  input  wire logic        blk_guard_ok_i,
  input  wire logic        blk_app_ok_i,
  input  wire logic        blk_ref_ok_i,
  // medium request
  output logic [63:0]      blk_lba_o,
  output logic             blk_req_o,
  output logic [63:0]      fetch_addr_o,
  output logic             lim_retry_o,
  output logic             force_media_o,
  output logic             pi_strip_o,
  output logic             chk_guard_o,
  output logic             chk_app_o,
  output logic             chk_ref_o,
  output logic [31:0]      ref_tag_o,
  output logic [15:0]      app_mask_o,
  output logic [15:0]      app_val_o,
  // completion
  output logic             cpl_valid_o,
  output logic [7:0]       cpl_status_o,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic [31:0]      reg_rdata_o
);
  import bccd_pkg::*;

  // ==========================================================
  // state
  bccd_state_s s;
  bccd_state_s next_s;
  logic [3:0]  pcf;
  logic        pi_fmt;
  logic        blk_bad;
  logic        cmd_take;
  logic        pi_reject;

  // protection field slice; dw13 and dw12 25:16 never read
  assign pcf     = cmd_dw12_i[`BCCD_PCF_HI:`BCCD_PCF_LO];
  assign pi_fmt  = s.ctrl[`BCCD_CTRL_PIFMT];
  assign cmd_take  = cmd_ready_o && cmd_valid_i;
  // invalid settings: protected namespace, nonzero field, settings unsupported
  assign pi_reject = pi_fmt && (pcf != 4'h0) && !s.ctrl[`BCCD_CTRL_PIOK];
  // disabled checks and absent metadata never fail a block
  assign blk_bad = !blk_data_eq_i
                 || (s.has_md && !blk_md_eq_i)
                 || (s.chk_guard && !blk_guard_ok_i)
                 || (s.chk_app && !blk_app_ok_i)
                 || (s.chk_ref && !blk_ref_ok_i);

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.cpl_valid = 1'b0;
    next_s.rdata = 32'h0000_0000;
    case (s.st)
      BCCD_IDLE: begin
        if (cmd_valid_i) begin
          next_s.lba = {cmd_dw11_i, cmd_dw10_i};
          next_s.left = {1'b0, cmd_dw12_i[`BCCD_NLB_HI:0]} + 17'h0_0001;
          next_s.miscmp = 1'b0;
          next_s.lim_retry = cmd_dw12_i[`BCCD_LR_BIT];
          next_s.force_media = cmd_dw12_i[`BCCD_FUA_BIT];
          next_s.has_md = cmd_has_md_i;
          next_s.fetch_addr = cmd_first_page_pointer_i;
          // pi fields only latched on protected namespaces
          next_s.pi_act = pi_fmt & pcf[`BCCD_PCF_ACT];
          next_s.chk_guard = pi_fmt & pcf[`BCCD_PCF_GUARD];
          next_s.chk_app = pi_fmt & pcf[`BCCD_PCF_APP];
          next_s.chk_ref = pi_fmt & pcf[`BCCD_PCF_REF];
          next_s.ref_tag = pi_fmt ? cmd_dw14_i : 32'h0000_0000;
          next_s.app_mask = pi_fmt ? cmd_dw15_i[`BCCD_MASK_HI:`BCCD_MASK_LO] : 16'h0000;
          next_s.app_val = pi_fmt ? cmd_dw15_i[`BCCD_VAL_HI:0] : 16'h0000;
          if (pi_reject) begin
            next_s.cpl_valid = 1'b1;
            next_s.cpl_status = `BCCD_SC_BADPI;
          end else begin
            next_s.st = BCCD_RUN;
          end
        end
      end
      BCCD_RUN: begin
        if (blk_valid_i) begin
          next_s.lba = s.lba + 64'h0000_0000_0000_0001;
          next_s.left = s.left - 17'h0_0001;
          if (blk_bad) begin
            next_s.miscmp = 1'b1;
            next_s.miscnt = s.miscnt + 16'h0001;
          end
          if (s.left == 17'h0_0001) begin
            next_s.st = BCCD_DONE;
          end
        end
      end
      BCCD_DONE: begin
        next_s.cpl_valid = 1'b1;
        next_s.cpl_status = s.miscmp ? `BCCD_SC_MISCMP : `BCCD_SC_OK;
        next_s.st = BCCD_IDLE;
      end
      default: begin
        next_s.st = BCCD_IDLE;
      end
    endcase
    // register access
    if (reg_we_i && reg_addr_i == `BCCD_REG_CTRL) begin
      next_s.ctrl = reg_wdata_i[1:0];
    end
    if (reg_re_i) begin
      case (reg_addr_i)
        `BCCD_REG_CTRL:   next_s.rdata = {30'h0000_0000, s.ctrl};
        `BCCD_REG_STAT:   next_s.rdata = {22'h00_0000, s.cpl_status, s.st};
        `BCCD_REG_LBA_LO: next_s.rdata = s.lba[31:0];
        `BCCD_REG_LBA_HI: next_s.rdata = s.lba[63:32];
        `BCCD_REG_MISCNT: next_s.rdata = {16'h0000, s.miscnt};
        default:          next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // registered state; constants only under reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign cmd_ready_o   = (s.st == BCCD_IDLE);
  assign blk_req_o     = (s.st == BCCD_RUN);
  assign blk_lba_o     = s.lba;
  assign fetch_addr_o  = s.fetch_addr;
  assign lim_retry_o   = s.lim_retry;
  assign force_media_o = s.force_media;
  assign pi_strip_o    = s.pi_act;
  assign chk_guard_o   = s.chk_guard;
  assign chk_app_o     = s.chk_app;
  assign chk_ref_o     = s.chk_ref;
  assign ref_tag_o     = s.ref_tag;
  assign app_mask_o    = s.app_mask;
  assign app_val_o     = s.app_val;
  assign cpl_valid_o   = s.cpl_valid;
  assign cpl_status_o  = s.cpl_status;
  assign reg_rdata_o   = s.rdata;

  // ==========================================================
  // assertions
  property p_done_cpl;
    @(posedge clk_i) disable iff (!rstn_i)
      s.st == BCCD_DONE |=> cpl_valid_o;
  endproperty
  a_done_cpl: assert property (p_done_cpl) else $error("no completion after done");

  property p_miscmp_status;
    @(posedge clk_i) disable iff (!rstn_i)
      (s.st == BCCD_DONE && s.miscmp) |=> cpl_status_o == `BCCD_SC_MISCMP;
  endproperty
  a_miscmp_status: assert property (p_miscmp_status) else $error("bad fail status");

  property p_ok_status;
    @(posedge clk_i) disable iff (!rstn_i)
      (s.st == BCCD_DONE && !s.miscmp) |=> cpl_status_o == `BCCD_SC_OK;
  endproperty
  a_ok_status: assert property (p_ok_status) else $error("bad ok status");

  property p_md_bad;
    @(posedge clk_i) disable iff (!rstn_i)
      (blk_req_o && blk_valid_i && s.has_md && !blk_md_eq_i) |=> s.miscmp;
  endproperty
  a_md_bad: assert property (p_md_bad) else $error("metadata miss lost");

  property p_lba;
    @(posedge clk_i) disable iff (!rstn_i)
      (cmd_ready_o && cmd_valid_i && !(pi_fmt && pcf != 4'h0 && !s.ctrl[1]))
      |=> blk_lba_o == {$past(cmd_dw11_i), $past(cmd_dw10_i)};
  endproperty
  a_lba: assert property (p_lba) else $error("start address wrong");

  property p_count;
    @(posedge clk_i) disable iff (!rstn_i)
      (cmd_ready_o && cmd_valid_i && !(pi_fmt && pcf != 4'h0 && !s.ctrl[1]))
      |=> s.left == {1'b0, $past(cmd_dw12_i[15:0])} + 17'h0_0001;
  endproperty
  a_count: assert property (p_count) else $error("block count wrong");

  property p_nopi;
    @(posedge clk_i) disable iff (!rstn_i)
      (cmd_ready_o && cmd_valid_i && !pi_fmt)
      |=> !(pi_strip_o || chk_guard_o || chk_app_o || chk_ref_o);
  endproperty
  a_nopi: assert property (p_nopi) else $error("pi used without format");

  property p_badpi;
    @(posedge clk_i) disable iff (!rstn_i)
      (cmd_ready_o && cmd_valid_i && pi_fmt && pcf != 4'h0 && !s.ctrl[1])
      |=> cpl_valid_o && cpl_status_o == `BCCD_SC_BADPI && cmd_ready_o;
  endproperty
  a_badpi: assert property (p_badpi) else $error("invalid pi not reported");

  property p_guard;
    @(posedge clk_i) disable iff (!rstn_i)
      (cmd_ready_o && cmd_valid_i && pi_fmt && s.ctrl[1])
      |=> chk_guard_o == $past(cmd_dw12_i[28]) && pi_strip_o == $past(cmd_dw12_i[29]);
  endproperty
  a_guard: assert property (p_guard) else $error("control mapping wrong");

  property p_strip;
    @(posedge clk_i) disable iff (!rstn_i)
      (cmd_take && pi_fmt && !pi_reject)
      |=> pi_strip_o == $past(pcf[`BCCD_PCF_ACT]);
  endproperty
  a_strip: assert property (p_strip) else $error("action bit not applied");

  property p_app_map;
    @(posedge clk_i) disable iff (!rstn_i)
      (cmd_take && pi_fmt && !pi_reject)
      |=> chk_app_o == $past(pcf[`BCCD_PCF_APP]);
  endproperty
  a_app_map: assert property (p_app_map) else $error("app tag enable wrong");

  property p_ref_map;
    @(posedge clk_i) disable iff (!rstn_i)
      (cmd_take && pi_fmt && !pi_reject)
      |=> chk_ref_o == $past(pcf[`BCCD_PCF_REF]);
  endproperty
  a_ref_map: assert property (p_ref_map) else $error("ref tag enable wrong");

  property p_guard_bad;
    @(posedge clk_i) disable iff (!rstn_i)
      (blk_req_o && blk_valid_i && chk_guard_o && !blk_guard_ok_i) |=> s.miscmp;
  endproperty
  a_guard_bad: assert property (p_guard_bad) else $error("guard failure lost");

  property p_app_bad;
    @(posedge clk_i) disable iff (!rstn_i)
      (blk_req_o && blk_valid_i && chk_app_o && !blk_app_ok_i) |=> s.miscmp;
  endproperty
  a_app_bad: assert property (p_app_bad) else $error("app tag failure lost");

  property p_ref_bad;
    @(posedge clk_i) disable iff (!rstn_i)
      (blk_req_o && blk_valid_i && chk_ref_o && !blk_ref_ok_i) |=> s.miscmp;
  endproperty
  a_ref_bad: assert property (p_ref_bad) else $error("ref tag failure lost");

  property p_data_bad;
    @(posedge clk_i) disable iff (!rstn_i)
      (blk_req_o && blk_valid_i && !blk_data_eq_i) |=> s.miscmp;
  endproperty
  a_data_bad: assert property (p_data_bad) else $error("data miss lost");

  property p_retry;
    @(posedge clk_i) disable iff (!rstn_i)
      (cmd_take && !pi_reject)
      |=> lim_retry_o == $past(cmd_dw12_i[`BCCD_LR_BIT]);
  endproperty
  a_retry: assert property (p_retry) else $error("retry bit wrong");

  property p_media;
    @(posedge clk_i) disable iff (!rstn_i)
      (cmd_take && !pi_reject)
      |=> force_media_o == $past(cmd_dw12_i[`BCCD_FUA_BIT]);
  endproperty
  a_media: assert property (p_media) else $error("forced access bit wrong");

  property p_fetch;
    @(posedge clk_i) disable iff (!rstn_i)
      (cmd_take && !pi_reject)
      |=> fetch_addr_o == $past(cmd_first_page_pointer_i);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address wrong");

  property p_tags;
    @(posedge clk_i) disable iff (!rstn_i)
      (cmd_take && pi_fmt && !pi_reject)
      |=> ref_tag_o == $past(cmd_dw14_i)
          && {app_mask_o, app_val_o} == $past(cmd_dw15_i);
  endproperty
  a_tags: assert property (p_tags) else $error("expected tags wrong");

  property p_busy_quiet;
    @(posedge clk_i) disable iff (!rstn_i)
      blk_req_o |-> !cpl_valid_o;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("completion while busy");

  property p_last;
    @(posedge clk_i) disable iff (!rstn_i)
      (blk_req_o && blk_valid_i && s.left == 17'h0_0001)
      |=> !blk_req_o ##1 cpl_valid_o;
  endproperty
  a_last: assert property (p_last) else $error("run did not end on count");

  c_ok:    cover property (@(posedge clk_i) cpl_valid_o && cpl_status_o == `BCCD_SC_OK);
  c_fail:  cover property (@(posedge clk_i) cpl_valid_o && cpl_status_o == `BCCD_SC_MISCMP);
  c_badpi: cover property (@(posedge clk_i) cpl_valid_o && cpl_status_o == `BCCD_SC_BADPI);
  c_md_miss: cover property (@(posedge clk_i) s.has_md && blk_valid_i && !blk_md_eq_i);
  c_nopi:  cover property (@(posedge clk_i) cmd_take && !pi_fmt);
endmodule

// ---- core/bccd_consts.svh ----
`ifndef BCCD_CONSTS_SVH
`define BCCD_CONSTS_SVH
// command dword 12 field positions
`define BCCD_LR_BIT        31
`define BCCD_FUA_BIT       30
`define BCCD_PCF_HI        29
`define BCCD_PCF_LO        26
`define BCCD_NLB_HI        15
// protection control field bits
`define BCCD_PCF_ACT       3
`define BCCD_PCF_GUARD     2
`define BCCD_PCF_APP       1
`define BCCD_PCF_REF       0
// command dword 15 split
`define BCCD_MASK_HI       31
`define BCCD_MASK_LO       16
`define BCCD_VAL_HI        15
// status codes
`define BCCD_SC_OK         8'h00
`define BCCD_SC_MISCMP     8'h85
`define BCCD_SC_BADPI      8'h81
// register offsets
`define BCCD_REG_CTRL      8'h00
`define BCCD_REG_STAT      8'h04
`define BCCD_REG_LBA_LO    8'h08
`define BCCD_REG_LBA_HI    8'h0C
`define BCCD_REG_MISCNT    8'h10
// ctrl bits
`define BCCD_CTRL_PIFMT    0
`define BCCD_CTRL_PIOK     1
`endif

// ---- core/bccd_pkg.sv ----
package bccd_pkg;
  typedef enum logic [1:0] {
    BCCD_IDLE = 2'b00,
    BCCD_RUN  = 2'b01,
    BCCD_DONE = 2'b11
  } bccd_state_e;

  typedef struct packed {
    bccd_state_e st;
    logic [63:0] lba;
    logic [16:0] left;
    logic        miscmp;
    logic [31:0] ref_tag;
    logic [15:0] app_mask;
    logic [15:0] app_val;
    logic        pi_act;
    logic        chk_guard;
    logic        chk_app;
    logic        chk_ref;
    logic        lim_retry;
    logic        force_media;
    logic        has_md;
    logic [63:0] fetch_addr;
    logic        cpl_valid;
    logic [7:0]  cpl_status;
    logic [1:0]  ctrl;
    logic [15:0] miscnt;
    logic [31:0] rdata;
  } bccd_state_s;
endpackage

// ---- sim/bccd_media_model.sv ----
`timescale 1ns/10ps
// ==========================================
// medium datapath stand-in, one result per block
module bccd_media_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // bench control
  input  wire logic        slow_i,
  input  wire logic [63:0] bad_lba_i,
  input  wire logic [1:0]  bad_kind_i,
  // block handshake
  input  wire logic        req_i,
  input  wire logic [63:0] lba_i,
  output logic             valid_o,
  output logic             data_eq_o,
  output logic             md_eq_o
);
  logic [1:0] gap;

  // a gap after each pulse lets the block address advance first
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap       <= 2'd0;
      valid_o   <= 1'b0;
      data_eq_o <= 1'b0;
      md_eq_o   <= 1'b0;
    end else if (valid_o) begin
      valid_o   <= 1'b0;
      data_eq_o <= ~data_eq_o;  // meaningless off valid
      md_eq_o   <= ~md_eq_o;
    end else if (req_i && gap == 2'd0) begin
      valid_o   <= 1'b1;
      data_eq_o <= !(bad_kind_i[0] && lba_i == bad_lba_i);
      md_eq_o   <= !(bad_kind_i[1] && lba_i == bad_lba_i);
      gap       <= slow_i ? 2'd3 : 2'd0;
    end else if (gap != 2'd0) begin
      gap <= gap - 2'd1;
    end
  end
endmodule

// ---- sim/tb_bccd.sv ----
`timescale 1ns/10ps
`include "bccd_consts.svh"
// ==========================================
// bench for the compare command decoder
module tb_bccd;
  import bccd_pkg::*;
  logic        clk_i, rstn_i, cmd_valid, has_md, ready, bvalid, deq, meq, req, slow;
  logic        lim, forced_medium_access_bit, strip, cg, ca, cr, cpl, we, re, re_d;
  logic [63:0] mdptr, first_page_pointer, second_page_pointer, lba_o, fetch, bad_lba;
  logic [31:0] dw10, dw11, dw12, dw13, dw14, dw15, ref_tag, wdata, rdata, seed;
  logic [15:0] mask, aval;
  logic [7:0]  status, addr;
  logic [1:0]  kind;
  logic [2:0]  pi_bad;
  logic [7:0]  exp_q[$];
  logic [31:0] rd_q[$];
  int          bad_count, cmp_count, nblk;

  bccd_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid),
    .cmd_mdptr_i(mdptr), .cmd_first_page_pointer_i(first_page_pointer), .cmd_second_page_pointer_i(second_page_pointer), .cmd_dw10_i(dw10),
    .cmd_dw11_i(dw11), .cmd_dw12_i(dw12), .cmd_dw13_i(dw13), .cmd_dw14_i(dw14),
    .cmd_dw15_i(dw15), .cmd_has_md_i(has_md), .cmd_ready_o(ready), .blk_valid_i(bvalid),
    .blk_data_eq_i(deq), .blk_md_eq_i(meq), .blk_guard_ok_i(!pi_bad[2]),
    .blk_app_ok_i(!pi_bad[1]), .blk_ref_ok_i(!pi_bad[0]), .blk_lba_o(lba_o), .blk_req_o(req),
    .fetch_addr_o(fetch),
    .lim_retry_o(lim), .force_media_o(forced_medium_access_bit), .pi_strip_o(strip), .chk_guard_o(cg),
    .chk_app_o(ca), .chk_ref_o(cr), .ref_tag_o(ref_tag), .app_mask_o(mask),
    .app_val_o(aval), .cpl_valid_o(cpl), .cpl_status_o(status), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata));

  bccd_media_model media (.clk_i(clk_i), .rstn_i(rstn_i), .slow_i(slow),
    .bad_lba_i(bad_lba), .bad_kind_i(kind), .req_i(req), .lba_i(lba_o),
    .valid_o(bvalid), .data_eq_o(deq), .md_eq_o(meq));

  function logic [31:0] nx();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic chk_val(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected value at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic chk_stat(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected status at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
  endtask

  // issue one command, check decoded controls unless it is rejected, wait for its completion
  task automatic issue(input logic [3:0] pcf, input logic [15:0] block_count_minus_one, input logic md,
                       input logic [1:0] k, input logic [7:0] st, input logic pi);
    logic [63:0] lba;
    lba = {nx(), nx()};
    nblk = 0;
    exp_q.push_back(st);
    dw10      <= lba[31:0];
    dw11      <= lba[63:32];
    dw12      <= {nx() & 32'hc3ff_0000 | {2'h0, pcf, 26'h0}} | {16'h0, block_count_minus_one};
    dw13      <= nx();
    dw14      <= nx();
    dw15      <= nx();
    first_page_pointer      <= {nx(), nx()};
    second_page_pointer      <= {nx(), nx()};
    mdptr     <= {nx(), nx() & 32'hffff_fffc};
    has_md    <= md;
    kind      <= k;
    bad_lba   <= lba + 64'h1;
    cmd_valid <= 1'b1;
    @(posedge clk_i);
    cmd_valid <= 1'b0;
    #1;
    if (st != `BCCD_SC_BADPI) begin
      chk_val(lba_o, lba);
      chk_val(fetch, first_page_pointer);
      chk_val({lim, forced_medium_access_bit}, dw12[31:30]);
      chk_val({strip, cg, ca, cr}, pi ? pcf : 4'h0);
      chk_val(ref_tag, pi ? dw14 : 32'h0);
      chk_val({mask, aval}, pi ? dw15 : 32'h0);
    end
    while (exp_q.size() != 0) @(posedge clk_i);
    chk_val(nblk, (st == `BCCD_SC_BADPI) ? 0 : block_count_minus_one + 1);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // clock, 8 ns period
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // monitor: completions, read data and consumed blocks
  always @(posedge clk_i) begin
    if (cpl) chk_stat(status, (exp_q.size() != 0) ? exp_q.pop_front() : 8'hff);
    if (re_d) chk_val(rdata, rd_q.pop_front());
    if (req && bvalid) nblk++;
    re_d <= re;
  end

  // watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    wrap_up();
  end

  initial begin
    {cmd_valid, has_md, we, re, pi_bad, slow, kind, addr, wdata} = '0;
    {mdptr, first_page_pointer, second_page_pointer, dw10, dw11, dw12, dw13, dw14, dw15, bad_lba} = '0;
    seed   = 32'h21e3;
    rstn_i = 1'b0;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    wr(`BCCD_REG_CTRL, 32'h3);
    rd(`BCCD_REG_CTRL, 32'h3);
    @(posedge clk_i);
    rd(8'hfc, 32'h0);
    for (int i = 0; i < 16; i++) issue(4'(i), 16'(i % 4), 1'b0, 2'b00, `BCCD_SC_OK, 1'b1);
    slow <= 1'b1;
    issue(4'hf, 16'd9, 1'b1, 2'b00, `BCCD_SC_OK, 1'b1);
    issue(4'h0, 16'd2, 1'b0, 2'b01, `BCCD_SC_MISCMP, 1'b1);
    issue(4'h0, 16'd2, 1'b1, 2'b10, `BCCD_SC_MISCMP, 1'b1);
    issue(4'h0, 16'd2, 1'b0, 2'b10, `BCCD_SC_OK, 1'b1);
    rd(`BCCD_REG_MISCNT, 32'h0000_0002);
    pi_bad <= 3'b100;
    issue(4'h4, 16'd1, 1'b0, 2'b00, `BCCD_SC_MISCMP, 1'b1);
    issue(4'hb, 16'd1, 1'b0, 2'b00, `BCCD_SC_OK, 1'b1);
    pi_bad <= 3'b011;
    issue(4'h2, 16'd1, 1'b0, 2'b00, `BCCD_SC_MISCMP, 1'b1);
    issue(4'h1, 16'd1, 1'b0, 2'b00, `BCCD_SC_MISCMP, 1'b1);
    issue(4'hc, 16'd1, 1'b0, 2'b00, `BCCD_SC_OK, 1'b1);
    wr(`BCCD_REG_CTRL, 32'h1);
    issue(4'h5, 16'd1, 1'b0, 2'b00, `BCCD_SC_BADPI, 1'b0);
    rd(`BCCD_REG_STAT, {22'h00_0000, `BCCD_SC_BADPI, 2'b00});
    wr(`BCCD_REG_CTRL, 32'h0);
    pi_bad <= 3'b111;
    issue(4'hb, 16'd1, 1'b0, 2'b00, `BCCD_SC_OK, 1'b0);
    wrap_up();
  end
endmodule
